// *** rtl/sep_pkg.sv ***
// Purpose: shared constants and types for the serial eeprom select/program block
// Assumes: core clock of 10 MHz; pins are sampled, never used as clocks
// Notes:   program times are in ms, cycle counts derive from the clock rate
package sep_pkg;
   // ==========================================================
   // clock and timing
   localparam int CLK_HZ     = 10_000_000;
   localparam int WC_MS      = 2;
   localparam int EC_MS      = 6;
   localparam int WL_MS      = 15;
   localparam int WC_CYC     = WC_MS * (CLK_HZ / 1000);
   localparam int EC_CYC     = EC_MS * (CLK_HZ / 1000);
   localparam int WL_CYC     = WL_MS * (CLK_HZ / 1000);
   localparam int CSL_NS     = 250;
   localparam int CSL_CYC    = (CSL_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int TMR_W      = 18;

   // ==========================================================
   // array organisation
   localparam int BYTE_DEPTH = 512;
   localparam int BYTE_DW    = 8;
   localparam int WORD_DEPTH = 256;
   localparam int WORD_DW    = 16;
   localparam int MAX_AW     = 9;
   localparam int MAX_DW     = 16;
   localparam int OPC_W      = 2;
   localparam int EXT_W      = 2;
   localparam logic ERASED_BIT = 1'b1;

   // ==========================================================
   // opcodes and extension codes
   localparam logic [1:0] OPC_ERASE  = 2'h3;
   localparam logic [1:0] OPC_READ   = 2'h2;
   localparam logic [1:0] OPC_WRITE  = 2'h1;
   localparam logic [1:0] OPC_EXT    = 2'h0;
   localparam logic [1:0] EXT_LOCK   = 2'h0;
   localparam logic [1:0] EXT_WRITE_WHOLE_ARRAY   = 2'h1;
   localparam logic [1:0] EXT_ERASE_WHOLE_ARRAY   = 2'h2;
   localparam logic [1:0] EXT_UNLOCK = 2'h3;

   // ==========================================================
   // types
   typedef enum logic [1:0] {PK_ERASE, PK_WRITE, PK_ERASE_WHOLE_ARRAY, PK_WRITE_WHOLE_ARRAY} sep_pkind_t;
   typedef enum logic [1:0] {SH_WAIT, SH_CMD, SH_READ, SH_DONE} sep_shst_t;
   typedef enum logic [0:0] {PG_IDLE, PG_RUN} sep_pgst_t;

   typedef struct packed {
      sep_pkind_t          kind;
      logic [MAX_AW-1:0]   addr;
      logic [MAX_DW-1:0]   data;
   } sep_preq_t;
endpackage

// *** rtl/sep_buf.sv ***
// Purpose: small valid/ready buffer between decoder and program engine
// Assumes: single clock, DEPTH of at least two
// Notes:   in_ready low means full; the writer must hold or drop its word
`timescale 1ns/1ps
`default_nettype none
module sep_buf #(
   parameter int W     = 8,
   parameter int DEPTH = 2
) (
   input  wire logic         core_clk,
   input  wire logic         arst_n,
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL = CW'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0]           rd;
      logic [PW-1:0]           wr;
      logic [CW-1:0]           cnt;
   } sep_buf_st_t;

   sep_buf_st_t s_ff;
   sep_buf_st_t nxt_s;
   logic        push;
   logic        pop;

   function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
      return (p == LAST) ? '0 : PW'(p + 1'b1);
   endfunction

   assign in_ready  = (s_ff.cnt != FULL);
   assign out_valid = (s_ff.cnt != '0);
   assign out_data  = s_ff.mem[s_ff.rd];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // ==========================================================
   // next state
   always_comb begin
      nxt_s = s_ff;
      if (push) begin
         nxt_s.mem[s_ff.wr] = in_data;
         nxt_s.wr = step(s_ff.wr);
      end
      if (pop) begin
         nxt_s.rd = step(s_ff.rd);
      end
      if (push && !pop) begin
         nxt_s.cnt = CW'(s_ff.cnt + 1'b1);
      end else if (pop && !push) begin
         nxt_s.cnt = CW'(s_ff.cnt - 1'b1);
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
endmodule
`default_nettype wire

// *** rtl/sep_ctrl.sv ***
// Purpose: select, decode and self-timed programming of a 3-wire serial eeprom
// Assumes: sel, sclk and serial_in come from pins; sclk is sampled, not a clock
// Notes:   array held in flip-flops; WIDE selects 256x16, else 512x8
`timescale 1ns/1ps
`default_nettype none
module sep_ctrl
   import sep_pkg::*;
#(
   parameter int          WIDE      = 0,
   parameter int unsigned WC_CYCLES = WC_CYC,
   parameter int unsigned EC_CYCLES = EC_CYC,
   parameter int unsigned WL_CYCLES = WL_CYC
) (
   input  wire logic core_clk,
   input  wire logic arst_n,
   input  wire logic sel,
   input  wire logic sclk,
   input  wire logic serial_in,
   output logic      serial_out,
   output logic      serial_out_oe_n,
   output logic      standby,
   output logic      ready
);
   localparam int AW    = (WIDE != 0) ? 8 : 9;
   localparam int DW    = (WIDE != 0) ? WORD_DW : BYTE_DW;
   localparam int DEPTH = (WIDE != 0) ? WORD_DEPTH : BYTE_DEPTH;
   localparam int SW    = OPC_W + AW + DW;
   localparam logic [5:0] N_ADR = 6'(OPC_W + AW);
   localparam logic [5:0] N_DAT = 6'(SW);
   localparam logic [4:0] RD_LAST = 5'(DW - 1);

   // ==========================================================
   // state
   typedef struct packed {
      logic [1:0]              sy_sel;
      logic [1:0]              sy_clk;
      logic [1:0]              sy_di;
      logic                    clk_prev;
      sep_shst_t               sh;
      logic [5:0]              cnt;
      logic [SW-1:0]           sreg;
      logic [AW-1:0]           rd_addr;
      logic [DW-1:0]           rd_word;
      logic [4:0]              rd_cnt;
      logic                    unlocked;
      logic                    stat_on;
      logic                    stat_show;
      sep_pgst_t               pg;
      sep_pkind_t              pkind;
      logic [AW-1:0]           paddr;
      logic [DW-1:0]           pdata;
      logic [TMR_W-1:0]        tmr;
      logic [DEPTH-1:0][DW-1:0] mem;
      logic                    dout;
      logic                    oe_n;
      logic                    stby;
      logic                    rdy;
   } sep_st_t;

   sep_st_t   s_ff;
   sep_st_t   nxt_s;
   logic      push_v;
   sep_preq_t push_d;
   logic      push_rdy;
   logic      pop_v;
   sep_preq_t pop_d;
   logic      pop_rdy;

   function automatic sep_preq_t mk_req(input sep_pkind_t k,
                                        input logic [AW-1:0] a,
                                        input logic [DW-1:0] d);
      sep_preq_t r;
      r      = '0;
      r.kind = k;
      r.addr = MAX_AW'(a);
      r.data = MAX_DW'(d);
      return r;
   endfunction

   // two words of room is enough; busy blocks new starts anyway
   sep_buf #(
      .W     ($bits(sep_preq_t)),
      .DEPTH (2)
   ) u_buf (
      .core_clk  (core_clk),
      .arst_n    (arst_n),
      .in_valid  (push_v),
      .in_ready  (push_rdy),
      .in_data   (push_d),
      .out_valid (pop_v),
      .out_ready (pop_rdy),
      .out_data  (pop_d)
   );

   assign pop_rdy = (s_ff.pg == PG_IDLE);

   // ==========================================================
   // next state
   always_comb begin
      logic          sel_s;
      logic          di_s;
      logic          rise;
      logic          bsy;
      logic          lock_ok;
      logic [1:0]    op;
      logic [SW-1:0] sr;
      logic [5:0]    k;
      sel_s   = s_ff.sy_sel[1];
      di_s    = s_ff.sy_di[1];
      rise    = s_ff.sy_clk[1] & ~s_ff.clk_prev;
      bsy     = (s_ff.pg != PG_IDLE) | pop_v;
      lock_ok = s_ff.unlocked & push_rdy;
      sr      = {s_ff.sreg[SW-2:0], di_s};
      k       = 6'(s_ff.cnt + 6'h01);
      op      = '0;
      nxt_s   = s_ff;
      push_v  = 1'b0;
      push_d  = '0;
      nxt_s.sy_sel   = {s_ff.sy_sel[0], sel};
      nxt_s.sy_clk   = {s_ff.sy_clk[0], sclk};
      nxt_s.sy_di    = {s_ff.sy_di[0], serial_in};
      nxt_s.clk_prev = s_ff.sy_clk[1];

      // ------- serial decoder
      if (!sel_s) begin
         nxt_s.sh  = SH_WAIT;
         nxt_s.cnt = '0;
         nxt_s.stat_show = s_ff.stat_on;
      end else if (rise) begin
         case (s_ff.sh)
            SH_WAIT: begin
               if (di_s && !bsy) begin
                  nxt_s.sh        = SH_CMD;
                  nxt_s.cnt       = '0;
                  nxt_s.stat_on   = 1'b0;
                  nxt_s.stat_show = 1'b0;
               end
            end
            SH_CMD: begin
               nxt_s.sreg = sr;
               nxt_s.cnt  = k;
               if (k == N_ADR) begin
                  op = sr[AW+1 -: 2];
                  nxt_s.sh = SH_DONE;
                  case (op)
                     OPC_READ: begin
                        nxt_s.sh      = SH_READ;
                        nxt_s.rd_addr = sr[AW-1:0];
                        nxt_s.rd_word = s_ff.mem[sr[AW-1:0]];
                        nxt_s.rd_cnt  = '0;
                        nxt_s.dout    = 1'b0;
                     end
                     OPC_ERASE: begin
                        push_v = lock_ok;
                        push_d = mk_req(PK_ERASE, sr[AW-1:0], '0);
                     end
                     OPC_WRITE: begin
                        nxt_s.sh = SH_CMD;
                     end
                     default: begin
                        case (sr[AW-1 -: EXT_W])
                           EXT_UNLOCK: nxt_s.unlocked = 1'b1;
                           EXT_LOCK:   nxt_s.unlocked = 1'b0;
                           EXT_ERASE_WHOLE_ARRAY: begin
                              push_v = lock_ok;
                              push_d = mk_req(PK_ERASE_WHOLE_ARRAY, '0, '0);
                           end
                           default:    nxt_s.sh = SH_CMD;
                        endcase
                     end
                  endcase
               end else if (k == N_DAT) begin
                  op = sr[SW-1 -: 2];
                  nxt_s.sh = SH_DONE;
                  push_v = lock_ok;
                  push_d = mk_req((op == OPC_WRITE) ? PK_WRITE : PK_WRITE_WHOLE_ARRAY,
                                  sr[SW-3 -: AW], sr[DW-1:0]);
               end
            end
            SH_READ: begin
               // sequential read keeps going until select drops
               nxt_s.dout    = s_ff.rd_word[DW-1];
               nxt_s.rd_word = {s_ff.rd_word[DW-2:0], 1'b0};
               nxt_s.rd_cnt  = 5'(s_ff.rd_cnt + 5'h01);
               if (s_ff.rd_cnt == RD_LAST) begin
                  nxt_s.rd_addr = AW'(s_ff.rd_addr + 1'b1);
                  nxt_s.rd_word = s_ff.mem[AW'(s_ff.rd_addr + 1'b1)];
                  nxt_s.rd_cnt  = '0;
               end
            end
            default: begin
            end
         endcase
      end
      if (push_v) begin
         nxt_s.stat_on = 1'b1;
      end

      // ------- program engine, independent of select
      case (s_ff.pg)
         PG_IDLE: begin
            if (pop_v) begin
               nxt_s.pg    = PG_RUN;
               nxt_s.pkind = pop_d.kind;
               nxt_s.paddr = pop_d.addr[AW-1:0];
               nxt_s.pdata = pop_d.data[DW-1:0];
               case (pop_d.kind)
                  PK_ERASE_WHOLE_ARRAY: nxt_s.tmr = TMR_W'(EC_CYCLES);
                  PK_WRITE_WHOLE_ARRAY: nxt_s.tmr = TMR_W'(WL_CYCLES);
                  default: nxt_s.tmr = TMR_W'(WC_CYCLES);
               endcase
               // erase phase up front, program lands at the end
               if (pop_d.kind == PK_ERASE_WHOLE_ARRAY || pop_d.kind == PK_WRITE_WHOLE_ARRAY) begin
                  for (int i = 0; i < DEPTH; i++) begin
                     nxt_s.mem[i] = {DW{ERASED_BIT}};
                  end
               end else begin
                  nxt_s.mem[pop_d.addr[AW-1:0]] = {DW{ERASED_BIT}};
               end
            end
         end
         PG_RUN: begin
            nxt_s.tmr = TMR_W'(s_ff.tmr - 1'b1);
            if (s_ff.tmr <= TMR_W'(1)) begin
               nxt_s.pg = PG_IDLE;
               if (s_ff.pkind == PK_WRITE) begin
                  nxt_s.mem[s_ff.paddr] = s_ff.pdata;
               end else if (s_ff.pkind == PK_WRITE_WHOLE_ARRAY) begin
                  for (int i = 0; i < DEPTH; i++) begin
                     nxt_s.mem[i] = s_ff.pdata;
                  end
               end
            end
         end
         default: nxt_s.pg = PG_IDLE;
      endcase

      // ------- pins
      if (nxt_s.sh != SH_READ) begin
         nxt_s.dout = ~bsy;
      end
      nxt_s.oe_n = ~(sel_s & ((nxt_s.sh == SH_READ) | nxt_s.stat_show));
      nxt_s.stby = ~sel_s & ~bsy;
      nxt_s.rdy  = ~bsy;
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         s_ff      <= '0;
         s_ff.mem  <= '1;
         s_ff.oe_n <= 1'b1;
         s_ff.stby <= 1'b1;
         s_ff.rdy  <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   assign serial_out      = s_ff.dout;
   assign serial_out_oe_n = s_ff.oe_n;
   assign standby         = s_ff.stby;
   assign ready           = s_ff.rdy;
endmodule
`default_nettype wire

// *** test/sep_chk.sv ***
// Purpose: port checker for the select/program control block
// Assumes: master keeps sclk high and low four core cycles each
// Notes:   pin synchronisers add a few cycles, so windows are padded
`timescale 1ns/1ps
`default_nettype none
module sep_chk #(
   parameter int unsigned WC_CYCLES = 20,
   parameter int unsigned WL_CYCLES = 150
) (
   input wire logic core_clk,
   input wire logic arst_n,
   input wire logic sel,
   input wire logic sclk,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe_n,
   input wire logic standby,
   input wire logic ready
);
   // ==========================================================
   // busy length
   logic [31:0] low_cnt_ff;
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         low_cnt_ff <= 32'h0;
      end else begin
         low_cnt_ff <= ready ? 32'h0 : low_cnt_ff + 32'h1;
      end
   end
   // ==========================================================
   // properties
   default clocking @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   sequence s_desel;
      !sel [*6];
   endsequence
   sequence s_busy;
      !ready [*4];
   endsequence
   oe_off_desel_a: assert property (s_desel |-> serial_out_oe_n)
      else $error("output driven while deselected");
   sel_wakes_a: assert property (sel [*6] |-> !standby)
      else $error("standby while selected");
   standby_busy_a: assert property (!ready [*2] |-> !standby)
      else $error("standby during program cycle");
   status_low_a: assert property (s_busy ##0 !serial_out_oe_n |-> !serial_out)
      else $error("status not low while busy");
   idle_quiet_a: assert property (standby [*4] |-> serial_out_oe_n)
      else $error("output driven in standby");
   desel_no_prog_a: assert property (!sel [*8] |-> !$fell(ready))
      else $error("program began while deselected");
   prog_min_a: assert property ($rose(ready) |-> low_cnt_ff >= WC_CYCLES - 2)
      else $error("program cycle too short");
   prog_max_a: assert property (low_cnt_ff <= WL_CYCLES + 4)
      else $error("program cycle never ends");
endmodule
`default_nettype wire

// *** test/sep_master.sv ***
// Purpose: behavioural serial bus master for the select/program block
// Assumes: driven just after a core clock edge
// Notes:   sclk stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module sep_master (
   input  wire logic core_clk,
   input  wire logic serial_out,
   input  wire logic serial_out_oe_n,
   output logic      sel,
   output logic      sclk,
   output logic      serial_in
);
   logic [31:0] rdata;
   wire logic   do_pin;
   // released pin reads inverted, so a late output enable shows up as a bad bit
   assign do_pin = serial_out_oe_n ? ~serial_out : serial_out;
   initial begin
      sel = 1'b0;
      sclk = 1'b0;
      serial_in = 1'b0;
      rdata = 32'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // ==========================================================
   // frame: four core cycles per phase, above the pin minimum
   task automatic xfer(input logic [31:0] b, input int n);
      sel = 1'b1;
      for (int i = n - 1; i >= 0; i--) begin
         serial_in = b[i];
         tick(4);
         rdata = {rdata[30:0], do_pin};
         sclk = 1'b1;
         tick(4);
         sclk = 1'b0;
      end
      tick(4);
      rdata = {rdata[30:0], do_pin};
      sel = 1'b0;
      serial_in = ~serial_in;
      tick(4);
   endtask
   // select again after a low gap and poll until ready shows
   task automatic status(output logic oe0, output logic st0, output logic st1);
      sel = 1'b1;
      tick(8);
      oe0 = serial_out_oe_n;
      st0 = do_pin;
      for (int k = 0; k < 300 && do_pin !== 1'b1; k++) tick(1);
      st1 = do_pin;
      sel = 1'b0;
      tick(4);
   endtask
endmodule
`default_nettype wire

// *** test/tb_top.sv ***
// Purpose: self-checking bench for the select/program block
// Assumes: byte-wide array, shortened program times
// Notes:   word-wide variant is not exercised here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import sep_pkg::*;
   logic core_clk, arst_n, sel, sclk, serial_in;
   logic serial_out, serial_out_oe_n, standby, ready;
   logic oe0, st0, st1;
   int   mismatches = 0;
   int   checks_done = 0;
   logic [16:0] rows [4] = '{{9'h000, 8'hA5}, {9'h1FF, 8'h01}, {9'h100, 8'h80},
                             {9'h0AA, 8'h00}};
   sep_ctrl #(.WC_CYCLES(40), .EC_CYCLES(60), .WL_CYCLES(150)) DUT (
      .core_clk(core_clk), .arst_n(arst_n), .sel(sel), .sclk(sclk),
      .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n), .standby(standby), .ready(ready));
   sep_master m (.core_clk(core_clk), .serial_out(serial_out),
      .serial_out_oe_n(serial_out_oe_n), .sel(sel), .sclk(sclk), .serial_in(serial_in));
   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // ==========================================================
   // helpers
   function automatic logic [31:0] c12(input logic [1:0] op, input logic [8:0] a);
      return {20'h0, 1'b1, op, a};
   endfunction
   function automatic logic [31:0] c20(input logic [1:0] op, input logic [8:0] a,
                                       input logic [7:0] d);
      return {12'h0, 1'b1, op, a, d};
   endfunction
   task automatic chk_bit(input string nm, input logic e, input logic s);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] s);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic wait_ready();
      for (int k = 0; k < 400 && ready !== 1'b1; k++) m.tick(1);
      chk_bit("ready", 1'b1, ready);
   endtask
   task automatic rd(input logic [8:0] a, input int pre, input logic [7:0] e);
      m.xfer(c20(OPC_READ, a, 8'h00), 20 + pre);
      chk_bit("dummy", 1'b0, m.rdata[8]);
      chk_byte("rdata", e, m.rdata[7:0]);
   endtask
   task automatic final_report();
      if (mismatches == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      final_report();
   end
   // ==========================================================
   // sequence
   initial begin
      arst_n = 1'b0;
      repeat (5) @(posedge core_clk);
      #1 arst_n = 1'b1;
      m.tick(3);
      chk_bit("standby", 1'b1, standby);
      chk_bit("oe_n", 1'b1, serial_out_oe_n);
      m.xfer(c20(OPC_WRITE, 9'h010, 8'h00), 20);
      chk_bit("ready", 1'b1, ready);
      rd(9'h010, 0, 8'hFF);
      m.xfer(c12(OPC_EXT, {EXT_UNLOCK, 7'h00}), 12);
      for (int i = 0; i < 4; i++) begin
         m.xfer(c20(OPC_WRITE, rows[i][16:8], rows[i][7:0]), 20);
         chk_bit("ready", 1'b0, ready);
         chk_bit("standby", 1'b0, standby);
         wait_ready();
         m.tick(2);
         chk_bit("standby", 1'b1, standby);
         rd(rows[i][16:8], 0, rows[i][7:0]);
      end
      m.xfer(c20(OPC_WRITE, 9'h020, 8'h3C), 20);
      m.status(oe0, st0, st1);
      chk_bit("oe_n", 1'b0, oe0);
      chk_bit("busy", 1'b0, st0);
      chk_bit("done", 1'b1, st1);
      rd(9'h020, 0, 8'h3C);
      m.xfer(c20(OPC_WRITE, 9'h000, 8'h66), 20);
      m.xfer(c12(OPC_ERASE, 9'h000), 12);
      wait_ready();
      rd(9'h000, 0, 8'h66);
      m.xfer(c20(OPC_WRITE, 9'h000, 8'h11) >> 5, 15);
      chk_bit("ready", 1'b1, ready);
      rd(9'h000, 0, 8'h66);
      m.xfer(c12(OPC_ERASE, 9'h1FF), 12);
      wait_ready();
      rd(9'h1FF, 0, 8'hFF);
      m.xfer(c20(OPC_EXT, {EXT_WRITE_WHOLE_ARRAY, 7'h00}, 8'h5A), 20);
      wait_ready();
      rd(9'h0AA, 2, 8'h5A);
      rd(9'h1FF, 0, 8'h5A);
      m.xfer(c12(OPC_EXT, {EXT_ERASE_WHOLE_ARRAY, 7'h00}), 12);
      wait_ready();
      rd(9'h100, 0, 8'hFF);
      m.xfer(c12(OPC_EXT, {EXT_LOCK, 7'h00}), 12);
      m.xfer(c20(OPC_WRITE, 9'h0AA, 8'h00), 20);
      chk_bit("ready", 1'b1, ready);
      rd(9'h0AA, 0, 8'hFF);
      final_report();
   end
endmodule
bind sep_ctrl sep_chk #(.WC_CYCLES(WC_CYCLES)) u_chk (
   .core_clk(core_clk), .arst_n(arst_n), .sel(sel), .sclk(sclk),
   .serial_in(serial_in), .serial_out(serial_out),
   .serial_out_oe_n(serial_out_oe_n), .standby(standby), .ready(ready));
`default_nettype wire
